// ---- core/htd_lock_det.sv ----
// Phase-window lock detector of the first loop.
`timescale 1ns/1ps
module htd_lock_det (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pd_tick,
    input wire logic [15:0] phase_err_ps,
    input wire logic [1:0] window_sel,
    input wire logic [13:0] lock_count,
    output logic lock_q
);
    logic [13:0] cnt_q;
    logic in_win;
    logic [13:0] lim;

    // Window width in picoseconds for a selector code.
    function automatic logic [15:0] win_ps(input logic [1:0] sel);
        case (sel)
            2'h0: win_ps = htd_pkg::WIN0_PS;
            2'h1: win_ps = htd_pkg::WIN1_PS;
            2'h2: win_ps = htd_pkg::WIN2_PS;
            default: win_ps = htd_pkg::WIN3_PS;
        endcase
    endfunction

    // Compare against the window; code 0 is treated as one count.
    assign in_win = phase_err_ps < win_ps(window_sel);
    assign lim = (lock_count == 14'h0000) ? 14'h0001 : lock_count;

    // Counts consecutive in-window comparisons, saturating at the limit.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 14'h0000;
            lock_q <= 1'b0;
        end else if (pd_tick) begin
            if (!in_win) begin
                cnt_q <= 14'h0000;
                lock_q <= 1'b0;
            end else begin
                if (cnt_q < lim) begin
                    cnt_q <= cnt_q + 14'h0001;
                end
                lock_q <= cnt_q >= lim - 14'h0001; // (no wrap at full count).
            end
        end
    end

    out_window_a: assert property (@(posedge clk) disable iff (!rst_n)
        pd_tick && !in_win |=> !lock_q && cnt_q == 14'h0000)
        else $error("lock survived an out-of-window comparison");
    lock_needs_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(lock_q) |-> $past(in_win) && cnt_q >= lim)
        else $error("lock rose before the programmed count");
endmodule

// ---- core/htd_pkg.sv ----
// Shared constants and types for the holdover tune and lock control block.
// How it works
// - Low trip code n trips at (n+1)/64.
// - Rail trip drops lock and raises holdover flags.
// - Enabled rail trip makes input switch event.
// - Manual mode drives DAC from manual code.
// - Mode bit: zero automatic, one manual.
// - Leave holdover after programmed consecutive lock counts.
// - Force bit enters holdover regardless of lock.
// - Forced holdover: fixed gives manual, else tracked.
// - Forced holdover switches only when unmasked.
// - Tracked value read back at bits 23:14.
// - Decode two capacitor selectors, 14-15 reserved.
// - Decode two resistor selectors, 5-7 reserved.
// - Feedback delay is code times 205 ps.
// - Reference delay is code times 205 ps.
// - Lock counter counts below selected phase window.
// - DAC update rate is compare rate divided.
// - Lock asserts after programmed count in window.
// - Mask bit blocks lock-loss holdover and switch.
package htd_pkg;
    // ------------------------------------------------------------
    // Register byte offsets.
    // ------------------------------------------------------------
    localparam logic [4:0] OFF_RAIL = 5'h00;
    localparam logic [4:0] OFF_TUNE = 5'h04;
    localparam logic [4:0] OFF_XTAL = 5'h08;
    localparam logic [4:0] OFF_RDBK = 5'h0C;
    localparam logic [4:0] OFF_LOOP = 5'h10;
    localparam logic [4:0] OFF_DIV = 5'h14;
    localparam logic [4:0] OFF_CTRL = 5'h18;
    localparam logic [4:0] OFF_STAT = 5'h1C;
    // ------------------------------------------------------------
    // Writable bit masks and reset value.
    // ------------------------------------------------------------
    localparam logic [31:0] WM_RAIL = 32'h000FCFE0;
    localparam logic [31:0] WM_TUNE = 32'hFFDFFFE0;
    localparam logic [31:0] WM_XTAL = 32'hC0000000;
    localparam logic [31:0] WM_LOOP = 32'hFF7777C0;
    localparam logic [31:0] WM_DIV = 32'hFFCFFFC0;
    localparam logic [31:0] WM_CTRL = 32'h00000001;
    localparam logic [31:0] REG_RST = 32'h00000000;
    // ------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------
    localparam int HIGH_TRIP_LSB = 14;
    localparam int LOW_TRIP_LSB = 6;
    localparam int RAIL_EN_BIT = 5;
    localparam int MAN_CODE_LSB = 22;
    localparam int MAN_SEL_BIT = 20;
    localparam int EXIT_CNT_LSB = 6;
    localparam int FORCE_BIT = 5;
    localparam int XTAL_LSB = 30;
    localparam int RDBK_LSB = 14;
    localparam int CAP4_LSB = 28;
    localparam int CAP3_LSB = 24;
    localparam int RES4_LSB = 20;
    localparam int RES3_LSB = 16;
    localparam int FB_DLY_LSB = 12;
    localparam int REF_DLY_LSB = 8;
    localparam int WIN_LSB = 6;
    localparam int DIV_LSB = 22;
    localparam int LOCK_CNT_LSB = 6;
    localparam int MASK_BIT = 0;
    // ------------------------------------------------------------
    // Analog scale and decode values.
    // ------------------------------------------------------------
    localparam logic [16:0] DAC_FULL = 17'h003FF;
    localparam int TRIP_SHIFT = 6;
    localparam logic [5:0] TRIP_TOP = 6'h3F;
    localparam logic [10:0] DLY_STEP_PS = 11'h0CD;
    localparam logic [15:0] WIN0_PS = 16'h157C;
    localparam logic [15:0] WIN1_PS = 16'h2710;
    localparam logic [15:0] WIN2_PS = 16'h48A8;
    localparam logic [15:0] WIN3_PS = 16'h9C40;
    localparam logic [3:0] CAP_LAST = 4'hD;
    localparam logic [2:0] RES_LAST = 3'h4;
    localparam logic [7:0] CAP4_PF [14] = '{8'h0A, 8'h0F, 8'h1D, 8'h22, 8'h2F,
        8'h34, 8'h42, 8'h47, 8'h67, 8'h6C, 8'h7A, 8'h7E, 8'h8D, 8'h92};
    localparam logic [7:0] CAP3_PF [14] = '{8'h0A, 8'h0B, 8'h0F, 8'h10, 8'h13,
        8'h14, 8'h18, 8'h19, 8'h1D, 8'h1E, 8'h21, 8'h22, 8'h26, 8'h27};
    localparam logic [14:0] RES_OHM [5] = '{15'h00C8, 15'h03E8, 15'h07D0,
        15'h0FA0, 15'h3E80};
    // ------------------------------------------------------------
    // Holdover state.
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_TRACK = 2'b01, ST_HOLD = 2'b10} htd_state_type;
endpackage

// ---- core/htd_top.sv ----
// AHB-Lite controlled holdover, tuning DAC and lock control block.
`timescale 1ns/1ps
module htd_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pd_tick,
    input wire logic [15:0] phase_error_ps,
    input wire logic pump_up,
    input wire logic pump_down,
    output logic [9:0] tune_code,
    output logic holdover_active,
    output logic clock_switch_event,
    output logic first_loop_lock_flag,
    output logic lock_status_pin,
    output logic holdover_status_pin,
    output logic rail_low_flag,
    output logic rail_high_flag,
    output logic [1:0] crystal_drive_amplitude,
    output logic [7:0] second_loop_cap_four_pf,
    output logic [7:0] second_loop_cap_three_pf,
    output logic [14:0] second_loop_res_four_ohm,
    output logic [14:0] second_loop_res_three_ohm,
    output logic loop_filter_reserved,
    output logic [10:0] feedback_path_delay_ps,
    output logic [10:0] reference_path_delay_ps
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ------------------------------------------------------------
    // Register storage and field views.
    // ------------------------------------------------------------
    logic [31:0] reg_q [8];
    logic wr_pend_q;
    logic [2:0] widx_q;
    logic [31:0] rail_w, tune_w, loop_w, div_w;
    logic rail_en, manual_sel, force_hold, switch_mask;
    logic [9:0] manual_code, div_code;
    logic [13:0] exit_code, lock_code;

    assign rail_w = reg_q[htd_pkg::OFF_RAIL[4:2]];
    assign tune_w = reg_q[htd_pkg::OFF_TUNE[4:2]];
    assign loop_w = reg_q[htd_pkg::OFF_LOOP[4:2]];
    assign div_w = reg_q[htd_pkg::OFF_DIV[4:2]];
    assign rail_en = rail_w[htd_pkg::RAIL_EN_BIT];
    assign manual_sel = tune_w[htd_pkg::MAN_SEL_BIT];
    assign force_hold = tune_w[htd_pkg::FORCE_BIT];
    assign manual_code = tune_w[htd_pkg::MAN_CODE_LSB +: 10];
    assign exit_code = tune_w[htd_pkg::EXIT_CNT_LSB +: 14];
    assign div_code = div_w[htd_pkg::DIV_LSB +: 10];
    assign lock_code = div_w[htd_pkg::LOCK_CNT_LSB +: 14];
    assign switch_mask = reg_q[htd_pkg::OFF_CTRL[4:2]][htd_pkg::MASK_BIT];

    // Writable mask per register index; read-only words get none.
    function automatic logic [31:0] wmask(input logic [2:0] idx);
        case (idx)
            htd_pkg::OFF_RAIL[4:2]: wmask = htd_pkg::WM_RAIL;
            htd_pkg::OFF_TUNE[4:2]: wmask = htd_pkg::WM_TUNE;
            htd_pkg::OFF_XTAL[4:2]: wmask = htd_pkg::WM_XTAL;
            htd_pkg::OFF_LOOP[4:2]: wmask = htd_pkg::WM_LOOP;
            htd_pkg::OFF_DIV[4:2]: wmask = htd_pkg::WM_DIV;
            htd_pkg::OFF_CTRL[4:2]: wmask = htd_pkg::WM_CTRL;
            default: wmask = 32'h00000000;
        endcase
    endfunction

    // ------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY.
    // ------------------------------------------------------------
    logic take, addr_ok;
    logic [2:0] ridx;
    logic [31:0] rd_word, wmerge;
    htd_pkg::htd_state_type state_q;
    logic [9:0] tracked_q;
    logic lock_raw;

    assign take = hsel && hready && htrans[1];
    assign addr_ok = haddr[31:5] == 27'h0000000;
    assign ridx = haddr[4:2];
    assign wmerge = (reg_q[widx_q] & ~wmask(widx_q)) | (hwdata & wmask(widx_q));

    // Read mux, forwarding a write still in its data phase.
    always_comb begin
        rd_word = reg_q[ridx];
        if (wr_pend_q && widx_q == ridx) begin
            rd_word = wmerge;
        end
        if (ridx == htd_pkg::OFF_RDBK[4:2]) begin
            rd_word = 32'h00000000;
            rd_word[htd_pkg::RDBK_LSB +: 10] = tracked_q;
        end
        if (ridx == htd_pkg::OFF_STAT[4:2]) begin
            rd_word = {26'h0000000, state_q, rail_high_flag, rail_low_flag,
                lock_raw, holdover_active};
        end
        if (!addr_ok) begin
            rd_word = 32'h00000000;
        end
    end

    // Address phase capture for writes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            widx_q <= 3'h0;
        end else begin
            wr_pend_q <= take && hwrite && addr_ok;
            widx_q <= ridx;
        end
    end

    // Data phase write; read-only words keep their value.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 8; i++) begin
                reg_q[i] <= htd_pkg::REG_RST;
            end
        end else if (wr_pend_q) begin
            reg_q[widx_q] <= wmerge;
        end
    end

    // Read data registered at the address phase; response fixed OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (take && !hwrite) begin
                hrdata <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------
    // Rail trip detection on the tune code.
    // ------------------------------------------------------------
    logic trip_low, trip_high, rail_hit, rail_q;
    logic [16:0] code_scaled;

    // Threshold (n+1)/64 of full scale, as a DAC code times 64.
    function automatic logic [16:0] trip_lvl(input logic [5:0] n);
        trip_lvl = 17'({11'h000, n} + 17'h00001) * htd_pkg::DAC_FULL;
    endfunction

    assign code_scaled = {7'h00, tune_code} << htd_pkg::TRIP_SHIFT;
    assign trip_low = code_scaled <= trip_lvl(rail_w[htd_pkg::LOW_TRIP_LSB +: 6]);
    assign trip_high = code_scaled >=
        trip_lvl(htd_pkg::TRIP_TOP - rail_w[htd_pkg::HIGH_TRIP_LSB +: 6]) - htd_pkg::DAC_FULL;
    assign rail_hit = rail_en && (trip_low || trip_high);

    // Rail flags, visible in status and routed to the status pins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rail_q <= 1'b0;
            rail_low_flag <= 1'b0;
            rail_high_flag <= 1'b0;
        end else begin
            rail_q <= rail_hit;
            rail_low_flag <= rail_en && trip_low;
            rail_high_flag <= rail_en && trip_high;
        end
    end

    // ------------------------------------------------------------
    // Lock detection and holdover control.
    // ------------------------------------------------------------
    logic [13:0] exit_cnt_q, exit_lim;
    logic lock_d, exit_done, enter_hold;
    htd_pkg::htd_state_type state_d;

    htd_lock_det u_lock (
        .clk(hclk),
        .rst_n(hresetn),
        .pd_tick(pd_tick),
        .phase_err_ps(phase_error_ps),
        .window_sel(loop_w[htd_pkg::WIN_LSB +: 2]),
        .lock_count(lock_code),
        .lock_q(lock_raw)
    );

    assign exit_lim = (exit_code == 14'h0000) ? 14'h0001 : exit_code;
    assign exit_done = exit_cnt_q >= exit_lim && !force_hold && !rail_hit;
    assign enter_hold = force_hold || rail_hit ||
        (first_loop_lock_flag && !lock_raw && !switch_mask);

    // Next holdover state.
    always_comb begin
        case (state_q)
            htd_pkg::ST_TRACK: state_d = enter_hold ? htd_pkg::ST_HOLD : htd_pkg::ST_TRACK;
            htd_pkg::ST_HOLD: state_d = exit_done ? htd_pkg::ST_TRACK : htd_pkg::ST_HOLD;
            default: state_d = htd_pkg::ST_HOLD;
        endcase
    end

    // Lock flag and lock pin report lock only outside holdover.
    assign lock_d = lock_raw && state_d == htd_pkg::ST_TRACK;

    // Holdover state and its pin views.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= htd_pkg::ST_TRACK;
            holdover_active <= 1'b0;
            first_loop_lock_flag <= 1'b0;
            lock_status_pin <= 1'b0;
            holdover_status_pin <= 1'b0;
        end else begin
            state_q <= state_d;
            holdover_active <= state_d == htd_pkg::ST_HOLD;
            first_loop_lock_flag <= lock_d;
            lock_status_pin <= lock_d && !rail_hit;
            holdover_status_pin <= state_d == htd_pkg::ST_HOLD || rail_hit;
        end
    end

    // Consecutive lock counts while in holdover.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exit_cnt_q <= 14'h0000;
        end else if (state_q != htd_pkg::ST_HOLD || !lock_raw) begin
            exit_cnt_q <= 14'h0000;
        end else if (pd_tick && exit_cnt_q < exit_lim) begin
            exit_cnt_q <= exit_cnt_q + 14'h0001;
        end
    end

    // Switch event on a new rail trip or an unmasked lock fall.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_switch_event <= 1'b0;
        end else begin
            clock_switch_event <= (rail_hit && !rail_q) ||
                (!switch_mask && first_loop_lock_flag && !lock_d);
        end
    end

    // ------------------------------------------------------------
    // DAC update divider, tracking and output code.
    // ------------------------------------------------------------
    logic [9:0] div_cnt_q, div_lim;
    logic dac_tick_q;

    assign div_lim = (div_code == 10'h000) ? 10'h001 : div_code;

    // One DAC update every div_lim compare ticks.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_q <= 10'h000;
            dac_tick_q <= 1'b0;
        end else begin
            dac_tick_q <= 1'b0;
            if (pd_tick) begin
                if (div_cnt_q + 10'h001 >= div_lim) begin
                    div_cnt_q <= 10'h000;
                    dac_tick_q <= 1'b1;
                end else begin
                    div_cnt_q <= div_cnt_q + 10'h001;
                end
            end
        end
    end

    // Tracked value follows the pump and freezes in holdover.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tracked_q <= 10'h000;
        end else if (dac_tick_q && state_q == htd_pkg::ST_TRACK && !manual_sel) begin
            if (pump_up && !pump_down && tracked_q != 10'h3FF) begin
                tracked_q <= tracked_q + 10'h001;
            end else if (pump_down && !pump_up && tracked_q != 10'h000) begin
                tracked_q <= tracked_q - 10'h001;
            end
        end
    end

    // DAC code: manual when selected, else the tracked value.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tune_code <= 10'h000;
        end else begin
            tune_code <= manual_sel ? manual_code : tracked_q;
        end
    end

    // ------------------------------------------------------------
    // Loop filter, delay and crystal drive decode.
    // ------------------------------------------------------------
    logic [3:0] c4, c3;
    logic [2:0] r4, r3;

    // Resistor selector to ohms; reserved codes give zero.
    function automatic logic [14:0] res_ohm(input logic [2:0] code);
        res_ohm = (code > htd_pkg::RES_LAST) ? 15'h0000 : htd_pkg::RES_OHM[code];
    endfunction

    assign c4 = loop_w[htd_pkg::CAP4_LSB +: 4];
    assign c3 = loop_w[htd_pkg::CAP3_LSB +: 4];
    assign r4 = loop_w[htd_pkg::RES4_LSB +: 3];
    assign r3 = loop_w[htd_pkg::RES3_LSB +: 3];

    // Registered decode of the selector fields.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            second_loop_cap_four_pf <= 8'h00;
            second_loop_cap_three_pf <= 8'h00;
            second_loop_res_four_ohm <= 15'h0000;
            second_loop_res_three_ohm <= 15'h0000;
            loop_filter_reserved <= 1'b0;
            feedback_path_delay_ps <= 11'h000;
            reference_path_delay_ps <= 11'h000;
            crystal_drive_amplitude <= 2'h0;
        end else begin
            second_loop_cap_four_pf <= (c4 > htd_pkg::CAP_LAST) ? 8'h00
                : htd_pkg::CAP4_PF[c4];
            second_loop_cap_three_pf <= (c3 > htd_pkg::CAP_LAST) ? 8'h00
                : htd_pkg::CAP3_PF[c3];
            second_loop_res_four_ohm <= res_ohm(r4);
            second_loop_res_three_ohm <= res_ohm(r3);
            loop_filter_reserved <= c4 > htd_pkg::CAP_LAST || c3 > htd_pkg::CAP_LAST ||
                r4 > htd_pkg::RES_LAST || r3 > htd_pkg::RES_LAST;
            feedback_path_delay_ps <= 11'(loop_w[htd_pkg::FB_DLY_LSB +: 3] *
                htd_pkg::DLY_STEP_PS);
            reference_path_delay_ps <= 11'(loop_w[htd_pkg::REF_DLY_LSB +: 3] *
                htd_pkg::DLY_STEP_PS);
            crystal_drive_amplitude <= reg_q[htd_pkg::OFF_XTAL[4:2]][htd_pkg::XTAL_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    sequence rail_rise_s;
        rail_hit && !rail_q;
    endsequence
    sequence hold_two_s;
        (state_q == htd_pkg::ST_HOLD && !manual_sel) [*2];
    endsequence

    force_enter_a: assert property (force_hold |=> state_q == htd_pkg::ST_HOLD)
        else $error("force did not enter holdover");
    rail_switch_a: assert property (rail_rise_s |=> clock_switch_event ##0
        state_q == htd_pkg::ST_HOLD)
        else $error("rail trip missed switch event or holdover");
    rail_disabled_a: assert property (!rail_en |=> !rail_low_flag && !rail_high_flag)
        else $error("rail flag raised while detection disabled");
    manual_code_a: assert property (manual_sel |=> tune_code == $past(manual_code))
        else $error("DAC not driven from manual code");
    tracked_freeze_a: assert property (hold_two_s |-> $stable(tracked_q))
        else $error("tracked value moved during holdover");
    masked_fall_a: assert property (switch_mask && !rail_hit && !rail_q
        |=> !clock_switch_event)
        else $error("switch event despite lock loss mask");
    hold_exit_a: assert property ($fell(holdover_active)
        |-> $past(exit_cnt_q) >= $past(exit_lim))
        else $error("holdover left before exit count");
    readback_a: assert property (take && !hwrite && addr_ok &&
        ridx == htd_pkg::OFF_RDBK[4:2] |=> hrdata[htd_pkg::RDBK_LSB +: 10] == $past(tracked_q))
        else $error("readback word lacks tracked value");
    divider_a: assert property (dac_tick_q |-> $past(pd_tick) && div_cnt_q == 10'h000)
        else $error("DAC update without divider wrap");
    delay_a: assert property (##1 feedback_path_delay_ps ==
        11'($past(loop_w[htd_pkg::FB_DLY_LSB +: 3]) * htd_pkg::DLY_STEP_PS))
        else $error("feedback delay decode wrong");
endmodule

// ---- sim/holdover_tune_dac_lock_control_tb.sv ----
// Register-driven testbench of the holdover tune and lock block.
`timescale 1ns/1ps
module holdover_tune_dac_lock_control_tb;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, pd_tick = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [15:0] phase_error_ps = 16'h0;
    logic pump_up, pump_down, hreadyout, hold, sw, lk, lsp, hsp, rlo, rsv, rhi, rsp;
    logic [1:0] xtl;
    logic [9:0] tune_code;
    logic [7:0] c4, c3;
    logic [14:0] r4, r3;
    logic [10:0] fbd, rfd;
    int errors = 0, num_checks = 0, sw_n = 0;
    htd_top i_htd_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(rsp), .hrdata(hrdata), .pd_tick(pd_tick),
        .phase_error_ps(phase_error_ps), .pump_up(pump_up), .pump_down(pump_down),
        .tune_code(tune_code), .holdover_active(hold), .clock_switch_event(sw),
        .first_loop_lock_flag(lk), .lock_status_pin(lsp), .holdover_status_pin(hsp),
        .rail_low_flag(rlo), .rail_high_flag(rhi), .crystal_drive_amplitude(xtl),
        .second_loop_cap_four_pf(c4), .second_loop_cap_three_pf(c3),
        .second_loop_res_four_ohm(r4), .second_loop_res_three_ohm(r3),
        .loop_filter_reserved(rsv), .feedback_path_delay_ps(fbd),
        .reference_path_delay_ps(rfd));
    htd_osc_model i_htd_osc_model (.hclk(hclk), .tune_code(tune_code), .pump_up(pump_up),
        .pump_down(pump_down));
    // ------------------------------------------------------------
    // Clock, event counting and shared tasks.
    // ------------------------------------------------------------
    initial forever #12.5 hclk = ~hclk;
    always @(posedge hclk) if (sw === 1'h1) sw_n++;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // One single AHB transfer; the read word lands in r.
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        r = hrdata;
        chk("hresp", {31'h0, rsp}, 32'h0);
    endtask
    // One phase comparison with the given error.
    task automatic tk(input logic [15:0] e);
        @(posedge hclk);
        pd_tick <= 1'h1;
        phase_error_ps <= e;
        @(posedge hclk);
        pd_tick <= 1'h0;
    endtask
    task automatic print_verdict;
        if (errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        repeat (3000) @(posedge hclk);
        errors++;
        print_verdict;
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (2) @(posedge hclk);
        bus(1'h0, htd_pkg::OFF_STAT, 32'h0);
        chk("status", r, 32'h10);
        bus(1'h1, htd_pkg::OFF_LOOP, 32'hD1457340);
        bus(1'h0, htd_pkg::OFF_LOOP, 32'h0);
        chk("loop rd", r, 32'hD1457340);
        chk("cap4", c4, 8'h92);
        chk("cap3", c3, 8'h0B);
        chk("res4", r4, 15'h3E80);
        chk("res3", {r3, rsv}, 16'h0001);
        chk("fbd", fbd, 11'h59B);
        chk("rfd", rfd, 11'h267);
        bus(1'h1, htd_pkg::OFF_DIV, 32'h004000C0);
        repeat (2) tk(16'h1388);
        tk(16'h2710);
        repeat (2) tk(16'h1388);
        repeat (2) @(posedge hclk);
        chk("lock early", lk, 1'h0);
        tk(16'h1388);
        repeat (2) @(posedge hclk);
        chk("lock", {lk, lsp}, 2'h3);
        bus(1'h1, htd_pkg::OFF_TUNE, 32'hA94000A0);
        repeat (3) @(posedge hclk);
        chk("forced", {hold, lk}, 2'h2);
        chk("switch", sw_n, 1);
        bus(1'h0, htd_pkg::OFF_RDBK, 32'h0);
        repeat (2) tk(16'h1388);
        chk("readback", r, 32'h00018000);
        chk("tracked", tune_code, 10'h006);
        bus(1'h1, htd_pkg::OFF_TUNE, 32'hA9400080);
        repeat (3) tk(16'h1388);
        repeat (2) @(posedge hclk);
        chk("exit", hold, 1'h0);
        bus(1'h1, htd_pkg::OFF_TUNE, 32'hA9500080);
        repeat (2) @(posedge hclk);
        chk("manual", tune_code, 10'h2A5);
        bus(1'h1, htd_pkg::OFF_CTRL, 32'h1);
        bus(1'h1, htd_pkg::OFF_TUNE, 32'hA95000A0);
        repeat (3) @(posedge hclk);
        chk("masked", sw_n, 1);
        chk("manual hold", tune_code, 10'h2A5);
        bus(1'h1, htd_pkg::OFF_TUNE, 32'h01500080);
        repeat (4) tk(16'h1388);
        tk(16'h2710);
        repeat (2) @(posedge hclk);
        chk("masked loss", {hold, lk}, 2'h0);
        repeat (3) tk(16'h1388);
        bus(1'h1, htd_pkg::OFF_CTRL, 32'h0);
        tk(16'h2710);
        repeat (3) @(posedge hclk);
        chk("loss hold", {hold, lk}, 2'h2);
        chk("loss switch", sw_n, 2);
        bus(1'h1, htd_pkg::OFF_RAIL, 32'h20);
        repeat (3) @(posedge hclk);
        chk("rail", {rlo, hold}, 2'h3);
        chk("pins", {hsp, lsp}, 2'h2);
        chk("rail switch", sw_n, 3);
        bus(1'h1, htd_pkg::OFF_TUNE, 32'hFFD00080);
        repeat (3) @(posedge hclk);
        chk("rail high", {rhi, rlo}, 2'h2);
        bus(1'h1, htd_pkg::OFF_XTAL, 32'hFFFFFFFF);
        bus(1'h0, htd_pkg::OFF_XTAL, 32'h0);
        chk("xtal rd", r, htd_pkg::WM_XTAL);
        chk("xtal", xtl, 2'h3);
        bus(1'h1, 32'h20, 32'hFFFFFFFF);
        bus(1'h0, 32'h20, 32'h0);
        chk("unmapped", r, 32'h0);
        print_verdict;
    end
endmodule

// ---- sim/htd_osc_model.sv ----
// Tunable oscillator model that steers the tracking loop.
`timescale 1ns/1ps
module htd_osc_model #(
    parameter logic [9:0] TARGET = 10'h100
) (
    input wire logic hclk,
    input wire logic [9:0] tune_code,
    output logic pump_up,
    output logic pump_down
);
    // Pump direction follows the sign of the tuning error.
    always_ff @(posedge hclk) begin
        pump_up <= tune_code < TARGET;
        pump_down <= tune_code > TARGET;
    end
endmodule
